// >>> logic/smc_lat_calc.sv
module smc_lat_calc
   import smc_pkg::*;
(
   input  wire logic [LAT_W-1:0] read_cas_delay_i,
   input  wire logic [LAT_W-1:0] parity_delay_i,
   input  wire logic [1:0]       add_code_i,
   input  wire logic [2:0]       cwl_code_i,
   output wire logic [LAT_W-1:0] additive_delay_o,
   output wire logic [LAT_W-1:0] write_cas_delay_o,
   output wire logic [LAT_W:0]   read_latency_o,
   output wire logic [LAT_W+1:0] write_latency_o
);
   function automatic logic [LAT_W-1:0] cwl_lookup(input logic [2:0] c);
      return CWL_CLOCKS[c*LAT_W +: LAT_W];
   endfunction

   wire logic [LAT_W-1:0] cl_m1 = read_cas_delay_i - 6'h01;
   wire logic [LAT_W-1:0] cl_m2 = read_cas_delay_i - 6'h02;

   // Reserved code 11 treated as zero delay
   assign additive_delay_o  = (add_code_i == AD_M1) ? cl_m1 :
                              (add_code_i == AD_M2) ? cl_m2 : 6'h00;
   assign write_cas_delay_o = cwl_lookup(cwl_code_i);
   assign read_latency_o    = {1'b0, additive_delay_o} + {1'b0, read_cas_delay_i};
   assign write_latency_o   = {2'b00, additive_delay_o} + {2'b00, parity_delay_i}
                            + {2'b00, write_cas_delay_o};
endmodule

// >>> logic/smc_mode_cfg.sv
module smc_mode_cfg
   import smc_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             ck_i,
   input  wire logic             cs_b_i,
   input  wire logic             ras_b_i,
   input  wire logic             cas_b_i,
   input  wire logic             we_b_i,
   input  wire logic [CFG_W-1:0] addr_i,
   input  wire logic             odt_i,
   input  wire logic             sref_i,
   input  wire logic             write_burst_i,
   input  wire logic             preamble_2ck_i,
   input  wire logic             quarter_rate_i,
   input  wire logic [LAT_W-1:0] read_cas_delay_i,
   input  wire logic [LAT_W-1:0] parity_delay_i,
   output logic                  write_levelling_enable_o,
   output logic [2:0]            receiver_equaliser_select_o,
   output logic                  eq_vendor_default_o,
   output logic [1:0]            driver_strength_select_o,
   output logic                  driver_reserved_o,
   output logic                  dll_running_o,
   output logic                  output_disable_o,
   output logic [2:0]            nominal_termination_o,
   output logic [2:0]            active_termination_o,
   output logic                  park_active_o,
   output logic                  write_allowed_o,
   output logic                  write_crc_enable_o,
   output logic [3:0]            write_burst_len_o,
   output logic [1:0]            self_refresh_temp_range_o,
   output logic [LAT_W-1:0]      additive_delay_o,
   output logic [LAT_W-1:0]      write_cas_delay_o,
   output logic [LAT_W:0]        read_latency_o,
   output logic [LAT_W+1:0]      write_latency_o,
   output logic                  config_illegal_o
);
   // Reset release
   logic rst_s1;
   logic rst_s2;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end
   wire logic rst_b = rst_s2;

   // Pin synchronisers, two flops each
   localparam int PIN_W = CFG_W + 8;
   logic [PIN_W-1:0] pin_s1;
   logic [PIN_W-1:0] pin_s2;
   wire  logic [PIN_W-1:0] pin_raw = {ck_i, cs_b_i, ras_b_i, cas_b_i, we_b_i,
                                      odt_i, sref_i, write_burst_i, addr_i};
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
      end
   end

   wire logic             ck_s     = pin_s2[PIN_W-1];
   wire logic             cs_b_s   = pin_s2[PIN_W-2];
   wire logic             ras_b_s  = pin_s2[PIN_W-3];
   wire logic             cas_b_s  = pin_s2[PIN_W-4];
   wire logic             we_b_s   = pin_s2[PIN_W-5];
   wire logic             odt_s    = pin_s2[PIN_W-6];
   wire logic             sref_s   = pin_s2[PIN_W-7];
   wire logic             wburst_s = pin_s2[PIN_W-8];
   wire logic [CFG_W-1:0] addr_s   = pin_s2[CFG_W-1:0];

   // Edge finder on the sampled link clock
   logic ck_d;
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         ck_d <= 1'b0;
      end else begin
         ck_d <= ck_s;
      end
   end
   wire logic ck_rise = ck_s & ~ck_d;

   // Mode-set decode on a rising link-clock edge
   wire logic mrs_hit = ck_rise & ~cs_b_s & ~ras_b_s & ~cas_b_s & ~we_b_s;
   smc_cmd_t cmd;
   assign cmd.mrs  = mrs_hit;
   assign cmd.sel  = addr_s[SEL_HI:SEL_LO];
   assign cmd.data = addr_s;

   wire logic hit_one = cmd.mrs && (cmd.sel == SEL_WORD_ONE);
   wire logic hit_two = cmd.mrs && (cmd.sel == SEL_WORD_TWO);

   // Stored words; unused selects ignored
   logic [CFG_W-1:0] device_mode_config_one;
   logic [CFG_W-1:0] write_path_mode_config;
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         device_mode_config_one <= WORD_ONE_RST;
         write_path_mode_config <= WORD_TWO_RST;
      end else begin
         if (hit_one) begin
            device_mode_config_one <= cmd.data;
         end
         if (hit_two) begin
            write_path_mode_config <= cmd.data;
         end
      end
   end

   // Field extraction
   smc_w1_t w1;
   smc_w2_t w2;
   assign w1.wlv      = device_mode_config_one[W1_WLV];
   assign w1.eq       = {device_mode_config_one[W1_EQ_HI],
                         device_mode_config_one[W1_EQ_MID],
                         device_mode_config_one[W1_EQ_LO]};
   assign w1.add_code = device_mode_config_one[W1_AD_HI:W1_AD_LO];
   assign w1.drv      = device_mode_config_one[W1_DRV_HI:W1_DRV_LO];
   assign w1.dll_en   = device_mode_config_one[W1_DLL];
   assign w1.qoff     = device_mode_config_one[W1_QOFF];
   assign w1.nom_term = device_mode_config_one[W1_NOM_HI:W1_NOM_LO];
   assign w2.crc_en   = write_path_mode_config[W2_CRC];
   assign w2.wr_term  = write_path_mode_config[W2_RWR_HI:W2_RWR_LO];
   assign w2.srt      = smc_srt_t'(write_path_mode_config[W2_SRT_HI:W2_SRT_LO]);
   assign w2.cwl_code = write_path_mode_config[W2_CWL_HI:W2_CWL_LO];

   // Delay loop state follows enable and self-refresh
   smc_loop_t loop_st;
   smc_loop_t next_loop_st;
   always_comb begin
      next_loop_st = loop_st;
      case (loop_st)
         LOOP_OFF: begin
            if (w1.dll_en) begin
               next_loop_st = sref_s ? LOOP_SREF : LOOP_ON;
            end
         end
         LOOP_ON: begin
            if (!w1.dll_en) begin
               next_loop_st = LOOP_OFF;
            end else if (sref_s) begin
               next_loop_st = LOOP_SREF;
            end
         end
         LOOP_SREF: begin
            if (!w1.dll_en) begin
               next_loop_st = LOOP_OFF;
            end else if (!sref_s) begin
               next_loop_st = LOOP_ON;
            end
         end
         default: next_loop_st = LOOP_OFF;
      endcase
   end
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         loop_st <= LOOP_ON;
      end else begin
         loop_st <= next_loop_st;
      end
   end
   wire logic loop_run = (loop_st == LOOP_ON);

   // Termination selection
   wire logic       rwr_valid   = (w2.wr_term <= RWR_MAX);
   wire logic       rwr_usable  = rwr_valid && !w1.wlv && (w2.wr_term != TERM_OFF);
   wire logic       in_write    = wburst_s && rwr_usable;
   wire logic [2:0] next_term   = in_write ? w2.wr_term :
                                  odt_s    ? w1.nom_term : TERM_OFF;
   wire logic       next_park   = !odt_s && !in_write;
   // Writes need the loop only when the write termination field is not off
   wire logic       next_wr_ok  = loop_run || (w2.wr_term == TERM_OFF);
   wire logic       eq_default  = (w1.eq == 3'h0);
   wire logic       drv_rsv     = (w1.drv != DRV_34) && (w1.drv != DRV_48);
   wire logic [3:0] next_burst  = w2.crc_en ? BURST_CRC : BURST_PLAIN;

   // Flag settings the controller must not choose
   wire logic bad_pre  = preamble_2ck_i && (w2.cwl_code < CWL_2PRE_MIN);
   wire logic bad_qr   = quarter_rate_i && ((w1.add_code == AD_M1) ||
                         (w2.cwl_code == 3'h0) || (w2.cwl_code == 3'h2));
   wire logic bad_rsv  = |(write_path_mode_config & W2_RSV_MASK);
   wire logic bad_off  = !loop_run && !w1.dll_en &&
                         ((w2.wr_term != TERM_OFF) || (w1.nom_term != TERM_OFF));
   wire logic next_illegal = bad_pre | bad_qr | bad_rsv | bad_off | !rwr_valid;

   wire logic [LAT_W-1:0] ad_w;
   wire logic [LAT_W-1:0] cwl_w;
   wire logic [LAT_W:0]   rl_w;
   wire logic [LAT_W+1:0] wl_w;
   smc_lat_calc u_lat (
      .read_cas_delay_i  (read_cas_delay_i),
      .parity_delay_i    (parity_delay_i),
      .add_code_i        (w1.add_code),
      .cwl_code_i        (w2.cwl_code),
      .additive_delay_o  (ad_w),
      .write_cas_delay_o (cwl_w),
      .read_latency_o    (rl_w),
      .write_latency_o   (wl_w)
   );

   // Registered outputs
   always_ff @(posedge clk_i or negedge rst_b) begin
      if (!rst_b) begin
         write_levelling_enable_o    <= 1'b0;
         receiver_equaliser_select_o <= 3'h0;
         eq_vendor_default_o         <= 1'b1;
         driver_strength_select_o    <= DRV_34;
         driver_reserved_o           <= 1'b0;
         dll_running_o               <= 1'b1;
         output_disable_o            <= 1'b0;
         nominal_termination_o       <= TERM_OFF;
         active_termination_o        <= TERM_OFF;
         park_active_o               <= 1'b1;
         write_allowed_o             <= 1'b1;
         write_crc_enable_o          <= 1'b0;
         write_burst_len_o           <= BURST_PLAIN;
         self_refresh_temp_range_o   <= SRT_NORMAL;
         additive_delay_o            <= '0;
         write_cas_delay_o           <= '0;
         read_latency_o              <= '0;
         write_latency_o             <= '0;
         config_illegal_o            <= 1'b0;
      end else begin
         write_levelling_enable_o    <= w1.wlv;
         receiver_equaliser_select_o <= w1.eq;
         eq_vendor_default_o         <= eq_default;
         driver_strength_select_o    <= w1.drv;
         driver_reserved_o           <= drv_rsv;
         dll_running_o               <= loop_run;
         output_disable_o            <= w1.qoff;
         nominal_termination_o       <= w1.nom_term;
         active_termination_o        <= next_term;
         park_active_o               <= next_park;
         write_allowed_o             <= next_wr_ok;
         write_crc_enable_o          <= w2.crc_en;
         write_burst_len_o           <= next_burst;
         self_refresh_temp_range_o   <= w2.srt;
         additive_delay_o            <= ad_w;
         write_cas_delay_o           <= cwl_w;
         read_latency_o              <= rl_w;
         write_latency_o             <= wl_w;
         config_illegal_o            <= next_illegal;
      end
   end

   // Checks
   sequence s_mrs_one;
      hit_one;
   endsequence
   property p_word_one_load;
      @(posedge clk_i) disable iff (!rst_b)
      s_mrs_one |=> (device_mode_config_one == $past(addr_s));
   endproperty
   a_word_one_load: assert property (p_word_one_load) else $error("word one not loaded");

   property p_word_hold;
      @(posedge clk_i) disable iff (!rst_b)
      !hit_two |=> $stable(write_path_mode_config);
   endproperty
   a_word_hold: assert property (p_word_hold) else $error("word two changed unprompted");

   property p_wlv_out;
      @(posedge clk_i) disable iff (!rst_b)
      hit_one ##1 1'b1 |=> (write_levelling_enable_o == $past(addr_s[W1_WLV], 2));
   endproperty
   a_wlv_out: assert property (p_wlv_out) else $error("write levelling wrong");

   property p_sref_off;
      @(posedge clk_i) disable iff (!rst_b)
      (loop_st == LOOP_ON && sref_s && w1.dll_en) |=> ##1 !dll_running_o;
   endproperty
   a_sref_off: assert property (p_sref_off) else $error("loop not off in self-refresh");

   property p_qoff;
      @(posedge clk_i) disable iff (!rst_b)
      w1.qoff |=> output_disable_o;
   endproperty
   a_qoff: assert property (p_qoff) else $error("outputs not disabled");

   property p_wlv_noterm;
      @(posedge clk_i) disable iff (!rst_b)
      w1.wlv |=> (active_termination_o == $past(odt_s ? w1.nom_term : TERM_OFF));
   endproperty
   a_wlv_noterm: assert property (p_wlv_noterm) else $error("write term in levelling");

   property p_crc_burst;
      @(posedge clk_i) disable iff (!rst_b)
      w2.crc_en |=> (write_burst_len_o == BURST_CRC);
   endproperty
   a_crc_burst: assert property (p_crc_burst) else $error("crc burst not ten");

   property p_rl;
      @(posedge clk_i) disable iff (!rst_b)
      // Output flops still hold reset values one edge after release
      rst_b |=> (read_latency_o == $past(ad_w) + $past(read_cas_delay_i));
   endproperty
   a_rl: assert property (p_rl) else $error("read latency sum wrong");

   property p_park;
      @(posedge clk_i) disable iff (!rst_b)
      (!odt_s && !wburst_s) |=> park_active_o;
   endproperty
   a_park: assert property (p_park) else $error("park not applied");

   sequence s_mrs_two;
      hit_two;
   endsequence
   property p_word_two_load;
      @(posedge clk_i) disable iff (!rst_b)
      s_mrs_two |=> (write_path_mode_config == $past(addr_s));
   endproperty
   a_word_two_load: assert property (p_word_two_load) else $error("word two not loaded");

   property p_word_one_hold;
      @(posedge clk_i) disable iff (!rst_b)
      !hit_one |=> $stable(device_mode_config_one);
   endproperty
   a_word_one_hold: assert property (p_word_one_hold) else $error("word one changed unprompted");

   sequence s_sref_exit;
      (loop_st == LOOP_SREF) && !sref_s && w1.dll_en;
   endsequence
   property p_sref_back;
      @(posedge clk_i) disable iff (!rst_b)
      s_sref_exit |=> ##1 dll_running_o;
   endproperty
   a_sref_back: assert property (p_sref_back) else $error("loop not back after self-refresh");

   property p_wr_blocked;
      @(posedge clk_i) disable iff (!rst_b)
      (!loop_run && (w2.wr_term != TERM_OFF)) |=> !write_allowed_o;
   endproperty
   a_wr_blocked: assert property (p_wr_blocked) else $error("write allowed without loop");

   property p_burst_plain;
      @(posedge clk_i) disable iff (!rst_b)
      !w2.crc_en |=> (write_burst_len_o == BURST_PLAIN);
   endproperty
   a_burst_plain: assert property (p_burst_plain) else $error("plain burst not eight");

   property p_wl;
      @(posedge clk_i) disable iff (!rst_b)
      rst_b |=> (write_latency_o == $past(ad_w) + $past(parity_delay_i) + $past(cwl_w));
   endproperty
   a_wl: assert property (p_wl) else $error("write latency sum wrong");

   property p_wr_term_write;
      @(posedge clk_i) disable iff (!rst_b)
      (wburst_s && rwr_valid && !w1.wlv && (w2.wr_term != TERM_OFF))
         |=> (active_termination_o == $past(w2.wr_term));
   endproperty
   a_wr_term_write: assert property (p_wr_term_write) else $error("write term not applied");
endmodule

// >>> logic/smc_pkg.sv
package smc_pkg;
   localparam int CFG_W = 22;
   localparam int LAT_W = 6;

   localparam logic [2:0] SEL_WORD_ONE = 3'h1;
   localparam logic [2:0] SEL_WORD_TWO = 3'h2;
   localparam int SEL_HI  = 20;
   localparam int SEL_LO  = 18;

   // First-word field positions
   localparam int W1_WLV      = 7;
   localparam int W1_EQ_HI    = 13;
   localparam int W1_EQ_MID   = 6;
   localparam int W1_EQ_LO    = 5;
   localparam int W1_AD_HI    = 4;
   localparam int W1_AD_LO    = 3;
   localparam int W1_DRV_HI   = 2;
   localparam int W1_DRV_LO   = 1;
   localparam int W1_DLL      = 0;
   localparam int W1_QOFF     = 12;
   localparam int W1_NOM_HI   = 10;
   localparam int W1_NOM_LO   = 8;

   // Second-word field positions
   localparam int W2_CRC      = 12;
   localparam int W2_RWR_HI   = 11;
   localparam int W2_RWR_LO   = 9;
   localparam int W2_SRT_HI   = 7;
   localparam int W2_SRT_LO   = 6;
   localparam int W2_CWL_HI   = 5;
   localparam int W2_CWL_LO   = 3;
   // Reserved second-word bits 21, 17, 13, 8, 2, 1, 0
   localparam logic [CFG_W-1:0] W2_RSV_MASK = 22'h22_2107;

   // Reset values: loop enabled, everything else off
   localparam logic [CFG_W-1:0] WORD_ONE_RST = 22'h00_0001;
   localparam logic [CFG_W-1:0] WORD_TWO_RST = 22'h00_0000;

   localparam logic [1:0] AD_ZERO  = 2'h0;
   localparam logic [1:0] AD_M1    = 2'h1;
   localparam logic [1:0] AD_M2    = 2'h2;
   localparam logic [1:0] DRV_34   = 2'h0;
   localparam logic [1:0] DRV_48   = 2'h1;
   localparam logic [2:0] TERM_OFF = 3'h0;
   localparam logic [2:0] RWR_MAX  = 3'h4;
   localparam logic [2:0] CWL_2PRE_MIN = 3'h4;

   localparam logic [3:0] BURST_PLAIN = 4'h8;
   localparam logic [3:0] BURST_CRC   = 4'ha;

   // Write CAS delay in clocks, code 0 in the lowest slice
   localparam logic [8*LAT_W-1:0] CWL_CLOCKS = {6'h14, 6'h12, 6'h10, 6'h0e, 6'h0c, 6'h0b, 6'h0a, 6'h09};

   typedef enum logic [1:0] {
      SRT_NORMAL   = 2'b00,
      SRT_REDUCED  = 2'b01,
      SRT_EXTENDED = 2'b10,
      SRT_AUTO     = 2'b11
   } smc_srt_t;

   typedef enum logic [1:0] {
      LOOP_OFF  = 2'b00,
      LOOP_ON   = 2'b01,
      LOOP_SREF = 2'b10
   } smc_loop_t;

   typedef struct packed {
      logic       wlv;
      logic [2:0] eq;
      logic [1:0] add_code;
      logic [1:0] drv;
      logic       dll_en;
      logic       qoff;
      logic [2:0] nom_term;
   } smc_w1_t;

   typedef struct packed {
      logic       crc_en;
      logic [2:0] wr_term;
      smc_srt_t   srt;
      logic [2:0] cwl_code;
   } smc_w2_t;

   typedef struct packed {
      logic       mrs;
      logic [2:0] sel;
      logic [CFG_W-1:0] data;
   } smc_cmd_t;
endpackage

// >>> tb/smc_ctrl_model.sv
module smc_ctrl_model
   import smc_pkg::*;
(
   input  wire logic        clk_i,
   output logic             ck_o,
   output logic             cs_b_o,
   output logic             ras_b_o,
   output logic             cas_b_o,
   output logic             we_b_o,
   output logic [CFG_W-1:0] addr_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      ck_o = 1'b0;
      cs_b_o = 1'b1;
      ras_b_o = 1'b1;
      cas_b_o = 1'b1;
      we_b_o = 1'b1;
      addr_o = 22'h00_0000;
   end

   // One link clock period per command; link clock idles low between frames
   task automatic mode_set(input logic [2:0] sel, input logic [CFG_W-1:0] data);
      logic [CFG_W-1:0] word;
      word = data;
      word[SEL_HI:SEL_LO] = sel;
      @(posedge clk_i);
      #1;
      addr_o = word;
      cs_b_o = 1'b0;
      ras_b_o = 1'b0;
      cas_b_o = 1'b0;
      we_b_o = 1'b0;
      repeat (3) @(posedge clk_i);
      #1 ck_o = 1'b1;
      repeat (12) @(posedge clk_i);
      #1 ck_o = 1'b0;
      repeat (13) @(posedge clk_i);
      #1;
      cs_b_o = 1'b1;
      ras_b_o = 1'b1;
      cas_b_o = 1'b1;
      we_b_o = 1'b1;
      // Released bus must not keep showing the old word
      addr_o = ~word;
   endtask
endmodule

// >>> tb/tb_smc_mode_cfg.sv
module tb_smc_mode_cfg
   import smc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [5:0] CL = 6'h14;
   localparam logic [5:0] PL = 6'h04;
   localparam logic [7:0] CWL_TAB [8] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0e, 8'h10, 8'h12, 8'h14};

   logic             clk, rst_b, ck, cs_b, ras_b, cas_b, we_b, odt, sref, burst, pre2, qrate;
   logic [CFG_W-1:0] addr;
   logic [LAT_W-1:0] cl, pl, add_d, cwl_d;
   logic             wlv, eqd, drv_rsv, dll_run, qoff, park, wr_ok, crc, illegal;
   logic [2:0]       eq, nom, act;
   logic [1:0]       drv, srt;
   logic [3:0]       blen;
   logic [LAT_W:0]   rlat;
   logic [LAT_W+1:0] wlat;
   int               num_errors, comparisons;

   smc_ctrl_model ctrl_i (.clk_i(clk), .ck_o(ck), .cs_b_o(cs_b), .ras_b_o(ras_b), .cas_b_o(cas_b),
      .we_b_o(we_b), .addr_o(addr));

   smc_mode_cfg smc_mode_cfg_i (.clk_i(clk), .rst_b_i(rst_b), .ck_i(ck), .cs_b_i(cs_b), .ras_b_i(ras_b),
      .cas_b_i(cas_b), .we_b_i(we_b), .addr_i(addr), .odt_i(odt), .sref_i(sref), .write_burst_i(burst),
      .preamble_2ck_i(pre2), .quarter_rate_i(qrate), .read_cas_delay_i(cl), .parity_delay_i(pl),
      .write_levelling_enable_o(wlv), .receiver_equaliser_select_o(eq), .eq_vendor_default_o(eqd),
      .driver_strength_select_o(drv), .driver_reserved_o(drv_rsv), .dll_running_o(dll_run),
      .output_disable_o(qoff), .nominal_termination_o(nom), .active_termination_o(act),
      .park_active_o(park), .write_allowed_o(wr_ok), .write_crc_enable_o(crc), .write_burst_len_o(blen),
      .self_refresh_temp_range_o(srt), .additive_delay_o(add_d), .write_cas_delay_o(cwl_d),
      .read_latency_o(rlat), .write_latency_o(wlat), .config_illegal_o(illegal));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Pin levels pass two sync flops and an output flop; 8 clocks is ample margin
   task automatic set_pins(input logic o, input logic b, input logic s);
      @(posedge clk);
      #1;
      odt = o;
      burst = b;
      sref = s;
      repeat (8) @(posedge clk);
      #1;
   endtask

   task automatic wait_dll(input logic exp);
      int n;
      n = 0;
      while (dll_run !== exp && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(8'(dll_run), 8'(exp));
      if (n >= 20) results();
   endtask

   task automatic t_reset();
      chk({4'h0, blen}, 8'h08);
      chk({7'h0, dll_run}, 8'h01);
      chk({6'h0, eqd, wlv}, 8'h02);
      @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk({6'h0, dll_run, wr_ok}, 8'h03);
      chk(8'(add_d), 8'h00);
      $display("t_reset done");
   endtask

   task automatic t_word1();
      logic [1:0] c;
      logic [5:0] ad;
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         ctrl_i.mode_set(SEL_WORD_ONE, {8'h00, |c, c[0], 4'h0, c[0], 1'b0, |c, c, c, 1'b1});
         ad = (c == 2'h1) ? CL - 6'h01 : (c == 2'h2) ? CL - 6'h02 : 6'h00;
         chk({7'h0, wlv}, 8'(c[0]));
         chk({4'h0, eqd, eq}, (c == 2'h0) ? 8'h08 : 8'h05);
         chk(8'(add_d), 8'(ad));
         chk(8'(rlat), 8'(ad) + 8'(CL));
         chk({5'h0, drv_rsv, drv}, {5'h0, c[1], c});
         chk({7'h0, qoff}, 8'(c[0]));
      end
      $display("t_word1 done");
   endtask

   task automatic t_word2();
      logic [2:0] c;
      ctrl_i.mode_set(SEL_WORD_ONE, 22'h00_0009);
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         ctrl_i.mode_set(SEL_WORD_TWO, {9'h000, c[0], 3'h0, 1'b0, c[1:0], c, 3'h0});
         chk({7'h0, crc}, 8'(c[0]));
         chk(8'(blen), c[0] ? 8'h0a : 8'h08);
         chk(8'(srt), 8'(c[1:0]));
         chk(8'(cwl_d), CWL_TAB[i]);
         chk(wlat, CWL_TAB[i] + 8'h13 + 8'(PL));
      end
      $display("t_word2 done");
   endtask

   task automatic t_term();
      ctrl_i.mode_set(SEL_WORD_ONE, 22'h00_0201);
      chk(8'(nom), 8'h02);
      for (int k = 1; k <= 4; k++) begin
         ctrl_i.mode_set(SEL_WORD_TWO, 22'(k) << 9);
         set_pins(1'b1, 1'b1, 1'b0);
         chk(8'(act), 8'(k));
         set_pins(1'b1, 1'b0, 1'b0);
         chk({4'h0, park, act}, 8'h02);
         set_pins(1'b0, 1'b1, 1'b0);
         chk(8'(act), 8'(k));
         set_pins(1'b0, 1'b0, 1'b0);
         chk({4'h0, park, act}, 8'h08);
      end
      ctrl_i.mode_set(SEL_WORD_ONE, 22'h00_0281);
      set_pins(1'b1, 1'b1, 1'b0);
      chk(8'(act), 8'h02);
      set_pins(1'b0, 1'b0, 1'b0);
      $display("t_term done");
   endtask

   task automatic t_loop();
      ctrl_i.mode_set(SEL_WORD_ONE, 22'h00_0001);
      ctrl_i.mode_set(SEL_WORD_TWO, 22'h00_0000);
      set_pins(1'b0, 1'b0, 1'b1);
      wait_dll(1'b0);
      set_pins(1'b0, 1'b0, 1'b0);
      wait_dll(1'b1);
      ctrl_i.mode_set(SEL_WORD_ONE, 22'h00_0000);
      chk({6'h0, dll_run, wr_ok}, 8'h01);
      ctrl_i.mode_set(SEL_WORD_TWO, 22'h00_0200);
      chk({6'h0, wr_ok, illegal}, 8'h01);
      ctrl_i.mode_set(SEL_WORD_ONE, 22'h00_0001);
      chk({6'h0, wr_ok, dll_run}, 8'h03);
      $display("t_loop done");
   endtask

   task automatic t_illegal();
      logic [CFG_W-1:0] w1s [6] = '{22'h00_0001, 22'h00_0001, 22'h00_0009, 22'h00_0001, 22'h00_0001, 22'h00_0001};
      logic [CFG_W-1:0] w2s [6] = '{22'h00_0000, 22'h00_0020, 22'h00_0020, 22'h00_0010, 22'h00_0120, 22'h00_0a20};
      logic [5:0] p2s = 6'b00_0011;
      logic [5:0] qrs = 6'b00_1100;
      logic [5:0] exs = 6'b11_1101;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         #1;
         pre2 = p2s[i];
         qrate = qrs[i];
         ctrl_i.mode_set(SEL_WORD_ONE, w1s[i]);
         ctrl_i.mode_set(SEL_WORD_TWO, w2s[i]);
         chk({7'h0, illegal}, 8'(exs[i]));
      end
      @(posedge clk);
      #1;
      qrate = 1'b0;
      $display("t_illegal done");
   endtask

   task automatic t_select();
      ctrl_i.mode_set(SEL_WORD_ONE, 22'h00_0081);
      ctrl_i.mode_set(3'h0, 22'h00_0000);
      ctrl_i.mode_set(3'h7, 22'h00_0000);
      chk({6'h0, wlv, dll_run}, 8'h03);
      @(posedge clk);
      #1 rst_b = 1'b0;
      repeat (3) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk({5'h0, wlv, dll_run, crc}, 8'h02);
      ctrl_i.mode_set(SEL_WORD_TWO, 22'h00_1000);
      chk({6'h0, wlv, crc}, 8'h01);
      $display("t_select done");
   endtask

   initial begin
      rst_b = 1'b0;
      odt = 1'b0;
      sref = 1'b0;
      burst = 1'b0;
      pre2 = 1'b0;
      qrate = 1'b0;
      cl = CL;
      pl = PL;
      num_errors = 0;
      comparisons = 0;
      repeat (10) @(posedge clk);
      t_reset();
      t_word1();
      t_word2();
      t_term();
      t_loop();
      t_illegal();
      t_select();
      results();
   end
endmodule
